// ===== rtl/vdr_seq.sv
/*
 Pin sequencer: runs one random-port cycle on the device strobes.
 Assumes the device samples strobes asynchronously and every phase of
 one controller clock meets its timing at 10 MHz.
*/
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "vdr_map.svh"
module vdr_seq
	import vdr_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        start_i,
	input  wire logic [3:0]  op_i,
	input  wire logic [1:0]  lanes_i,
	input  wire logic        late_i,
	input  wire logic [8:0]  row_i,
	input  wire logic [8:0]  col_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [15:0] mask_i,
	input  wire logic        pers_i,
	input  wire logic [15:0] dq_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [15:0]      rdata_o,
	output logic [8:0]       addr_o,
	output logic             row_strobe_n_o,
	output logic             lower_byte_column_strobe_n_o,
	output logic             upper_byte_column_strobe_n_o,
	output logic             write_enable_n_o,
	output logic             transfer_output_enable_n_o,
	output logic             special_function_select_o,
	output logic [15:0]      dq_o,
	output logic [15:0]      dq_oe_o
);
	vdr_state_e  st_ff, nxt_st;
	logic [2:0]  cnt_ff, nxt_cnt;
	logic [15:0] rdata_ff, nxt_rdata;
	logic        ras_ff, nxt_ras, cas_ff, nxt_cas;
	logic        we_row, dsf_row, dsf_col, is_wr, is_rd, is_reg, cas_hi;
	vdr_op_e     op;

	assign op      = vdr_op_e'(op_i);
	// Write enable at row fall asks for masking; mask loads also sample it high.
	assign we_row  = (op == VDR_OP_MWRITE) || (op == VDR_OP_MBLOCK) ||
		(op == VDR_OP_FLASH);
	assign dsf_row = (op == VDR_OP_FLASH) || (op == VDR_OP_LMR) || (op == VDR_OP_LCR) ||
		(op == VDR_OP_RMR) || (op == VDR_OP_RCR);
	assign dsf_col = (op == VDR_OP_BLOCK) || (op == VDR_OP_MBLOCK) ||
		(op == VDR_OP_LCR) || (op == VDR_OP_RCR);
	assign is_rd   = (op == VDR_OP_READ) || (op == VDR_OP_RMR) || (op == VDR_OP_RCR);
	assign is_reg  = (op == VDR_OP_RMR) || (op == VDR_OP_RCR);
	assign is_wr   = !is_rd && (op != VDR_OP_REGISTER_RESET_REFRESH) && (op != VDR_OP_FLASH);
	assign cas_hi  = (op == VDR_OP_FLASH);
	assign busy_o  = (st_ff != VDR_IDLE);
	assign rdata_o = rdata_ff;

	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_rdata = rdata_ff;
		done_o    = 1'b0;
		case (st_ff)
			VDR_IDLE: begin
				if (start_i) begin
					nxt_st  = VDR_ROW;
					nxt_cnt = `VDR_PHASE_CYC;
				end
			end
			VDR_ROW: begin
				if (cnt_ff == 3'h0) begin
					nxt_st  = VDR_COL;
					nxt_cnt = `VDR_PHASE_CYC;
				end else begin
					nxt_cnt = cnt_ff - 3'h1;
				end
			end
			VDR_COL: begin
				if (cnt_ff == 3'h0) begin
					nxt_st  = VDR_WE;
					nxt_cnt = `VDR_ROW_HOLD_CYC;
				end else begin
					nxt_cnt = cnt_ff - 3'h1;
				end
			end
			VDR_WE: begin
				if (cnt_ff == 3'h0) begin
					nxt_st  = VDR_HOLD;
					nxt_cnt = `VDR_PHASE_CYC;
				end else begin
					nxt_cnt = cnt_ff - 3'h1;
				end
			end
			VDR_HOLD: begin
				// Sampled after column strobe rose; data stays valid until row rises.
				if (is_rd) begin
					nxt_rdata = dq_i;
					if (!is_reg) begin
						if (!lanes_i[0])
							nxt_rdata[7:0] = rdata_ff[7:0];
						if (!lanes_i[1])
							nxt_rdata[15:8] = rdata_ff[15:8];
					end
				end
				nxt_st = VDR_END;
			end
			VDR_END: begin
				done_o = 1'b1;
				nxt_st = VDR_IDLE;
			end
			default: nxt_st = VDR_IDLE;
		endcase
		// Strobes are registered and fall one cycle after their address, select and data;
		// write enable and write data release on the same edge that raises the column strobe.
		nxt_ras = ((nxt_st == VDR_ROW) && (nxt_cnt == 3'h0)) || (nxt_st == VDR_COL) ||
			(nxt_st == VDR_WE) || (nxt_st == VDR_HOLD);
		nxt_cas = ((nxt_st == VDR_COL) && (nxt_cnt == 3'h0)) || (nxt_st == VDR_WE);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st_ff    <= VDR_IDLE;
			cnt_ff   <= 3'h0;
			rdata_ff <= 16'h0000;
			ras_ff   <= 1'b0;
			cas_ff   <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			rdata_ff <= nxt_rdata;
			ras_ff   <= nxt_ras;
			cas_ff   <= nxt_cas;
		end
	end

	logic row_act, col_act, we_act, dsf_now, mask_phase, data_phase;
	logic late_wait;
	assign row_act    = (st_ff != VDR_IDLE) && (st_ff != VDR_END);
	assign col_act    = cas_ff && !cas_hi;
	assign late_wait  = late_i && (st_ff == VDR_COL);
	// Refresh with register reset drops the column strobes on entering the row
	// phase, one cycle before the row strobe falls.
	assign row_strobe_n_o = !ras_ff;
	assign lower_byte_column_strobe_n_o = !((col_act && lanes_i[0]) ||
		(op == VDR_OP_REGISTER_RESET_REFRESH && row_act));
	assign upper_byte_column_strobe_n_o = !((col_act && lanes_i[1]) ||
		(op == VDR_OP_REGISTER_RESET_REFRESH && row_act));
	// Early write drops write enable a cycle before the column strobe; late write after it.
	assign we_act = (st_ff == VDR_ROW) ? (we_row && op != VDR_OP_REGISTER_RESET_REFRESH) :
		((st_ff == VDR_COL || st_ff == VDR_WE) && is_wr && !late_wait) ||
		(op == VDR_OP_FLASH && row_act);
	assign write_enable_n_o = !we_act;
	assign dsf_now = (st_ff == VDR_ROW) ? dsf_row : (dsf_col && st_ff != VDR_IDLE);
	assign special_function_select_o = dsf_now;
	// Output enable stays high while writing so the pins never fight.
	assign transfer_output_enable_n_o = !(is_rd && row_act && st_ff != VDR_ROW);
	assign mask_phase = (st_ff == VDR_ROW) && we_row && !pers_i;
	assign data_phase = (st_ff == VDR_COL || st_ff == VDR_WE) && is_wr;
	assign addr_o = (st_ff == VDR_ROW) ? row_i :
		((op == VDR_OP_BLOCK || op == VDR_OP_MBLOCK) ?
		{col_i[8:3], 3'h0} : col_i);
	// Block writes carry the column mask on each byte's pins.
	assign dq_o    = mask_phase ? mask_i : wdata_i;
	assign dq_oe_o = (mask_phase || data_phase) ? 16'hffff : 16'h0000;

	vdr_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_HOLD) |-> !row_strobe_n_o && transfer_output_enable_n_o == !is_rd)
		else $error("row strobe not held during read sample");
	vdr_early_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_COL && is_wr && !late_i) |-> !write_enable_n_o)
		else $error("early write lacks write enable");
	vdr_late_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_COL && cnt_ff == 3'h0 && is_wr && late_i) |->
		write_enable_n_o ##1 !write_enable_n_o)
		else $error("late write order wrong");
	vdr_toe_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(dq_oe_o != 16'h0000) |-> transfer_output_enable_n_o)
		else $error("driving data with output enabled");
	vdr_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_ROW && pers_i) |-> dq_oe_o == 16'h0000)
		else $error("mask driven in persistent mode");
	vdr_newmask_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_ROW && we_row && !pers_i) |-> dq_o == mask_i && !write_enable_n_o)
		else $error("new mask not presented");
	vdr_lane_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_COL && !lanes_i[1] && op != VDR_OP_REGISTER_RESET_REFRESH) |->
		upper_byte_column_strobe_n_o)
		else $error("unselected lane strobed");
	vdr_block_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_COL && op == VDR_OP_BLOCK) |->
		special_function_select_o && addr_o[2:0] == 3'h0)
		else $error("block write select wrong");
	vdr_special_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st_ff == VDR_ROW && op == VDR_OP_LMR) |-> special_function_select_o)
		else $error("special select missing at row");
endmodule : vdr_seq

// ===== shared/vdr_map.svh
/*
 Timing counts, register offsets and field positions for the video DRAM random-port controller.
 Assumes a 10 MHz controller clock; every count is in controller clock cycles.
*/
// How it works
// - Controller keeps transfer/output enable high while driving write data.
// - New-mask write: mask on data pins at row strobe fall, 1 allows.
// - Register read: write enable high at column strobe fall and after; device drives.
// - Write enable high at row fall: unmasked block; low: masked block.
// - Special-function high at row strobe fall selects special cycles.
// - Special-function low at row, high at column fall selects block write.
`ifndef VDR_MAP_SVH
`define VDR_MAP_SVH
`define VDR_CSR_CTRL       4'h0
`define VDR_CSR_ADDR       4'h4
`define VDR_CSR_WDATA      4'h8
`define VDR_CSR_MASK       4'hc
`define VDR_CSR_STATUS     4'h0
`define VDR_CSR_RDATA      4'h4
`define VDR_CTRL_GO_BIT    0
`define VDR_CTRL_OP_LSB    4
`define VDR_CTRL_LANE_LSB  8
`define VDR_CTRL_LATE_BIT  10
`define VDR_STAT_BUSY_BIT  0
`define VDR_STAT_PERS_BIT  1
`define VDR_PHASE_CYC      3'h1
`define VDR_ROW_HOLD_CYC   3'h2
`endif

// ===== shared/vdr_pkg.sv
/*
 Types shared by the controller: operation codes and pin-sequencer states.
 Assumes vdr_map.svh provides the field positions.
*/
package vdr_pkg;
	typedef enum logic [3:0] {
		VDR_OP_READ   = 4'h0,
		VDR_OP_WRITE  = 4'h1,
		VDR_OP_MWRITE = 4'h2,
		VDR_OP_BLOCK  = 4'h3,
		VDR_OP_MBLOCK = 4'h4,
		VDR_OP_FLASH  = 4'h5,
		VDR_OP_LMR    = 4'h6,
		VDR_OP_LCR    = 4'h7,
		VDR_OP_RMR    = 4'h8,
		VDR_OP_RCR    = 4'h9,
		VDR_OP_REGISTER_RESET_REFRESH   = 4'ha
	} vdr_op_e;
	typedef enum logic [2:0] {
		VDR_IDLE = 3'b000,
		VDR_ROW  = 3'b001,
		VDR_COL  = 3'b010,
		VDR_WE   = 3'b011,
		VDR_HOLD = 3'b100,
		VDR_END  = 3'b101
	} vdr_state_e;
endpackage : vdr_pkg

// ===== rtl/vdr_ctrl.sv
/*
 Top of the video DRAM random-port controller: Avalon-MM slave registers
 that software uses to launch one device cycle and read back the result.
 Assumes the device pins connect straight to the sequencer outputs.
*/
`timescale 1ns/10ps
`include "vdr_map.svh"
module vdr_ctrl
	import vdr_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic [15:0] dq_i,
	output logic [8:0]       addr_o,
	output logic             row_strobe_n_o,
	output logic             lower_byte_column_strobe_n_o,
	output logic             upper_byte_column_strobe_n_o,
	output logic             write_enable_n_o,
	output logic             transfer_output_enable_n_o,
	output logic             special_function_select_o,
	output logic [15:0]      dq_o,
	output logic [15:0]      dq_oe_o
);
	logic [3:0]  op_ff, nxt_op;
	logic [1:0]  lane_ff, nxt_lane;
	logic        late_ff, nxt_late, go_ff, nxt_go, pers_ff, nxt_pers;
	logic [17:0] adr_ff, nxt_adr;
	logic [15:0] wd_ff, nxt_wd, msk_ff, nxt_msk;
	logic [31:0] rd_ff, nxt_rd;
	logic        ack_ff, nxt_ack, busy, done;
	logic [15:0] rdata;

	// One wait cycle on every access gives registered read data.
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
	assign avs_readdata_o    = rd_ff;

	always_comb begin
		nxt_op   = op_ff;
		nxt_lane = lane_ff;
		nxt_late = late_ff;
		nxt_adr  = adr_ff;
		nxt_wd   = wd_ff;
		nxt_msk  = msk_ff;
		nxt_go   = 1'b0;
		nxt_pers = pers_ff;
		nxt_rd   = rd_ff;
		nxt_ack  = (avs_read_i || avs_write_i) && !ack_ff;
		// Persistent masking follows what the device itself tracks.
		if (done && vdr_op_e'(op_ff) == VDR_OP_LMR)
			nxt_pers = 1'b1;
		else if (done && vdr_op_e'(op_ff) == VDR_OP_REGISTER_RESET_REFRESH)
			nxt_pers = 1'b0;
		// A write lands only at the edge where waitrequest is seen low.
		if (avs_write_i && ack_ff && !busy) begin
			if (avs_address_i == `VDR_CSR_CTRL) begin
				nxt_op   = avs_writedata_i[`VDR_CTRL_OP_LSB +: 4];
				nxt_lane = avs_writedata_i[`VDR_CTRL_LANE_LSB +: 2];
				nxt_late = avs_writedata_i[`VDR_CTRL_LATE_BIT];
				nxt_go   = avs_writedata_i[`VDR_CTRL_GO_BIT];
			end else if (avs_address_i == `VDR_CSR_ADDR) begin
				nxt_adr = avs_writedata_i[17:0];
			end else if (avs_address_i == `VDR_CSR_WDATA) begin
				nxt_wd = avs_writedata_i[15:0];
			end else if (avs_address_i == `VDR_CSR_MASK) begin
				nxt_msk = avs_writedata_i[15:0];
			end
		end
		if (avs_read_i && !ack_ff) begin
			if (avs_address_i == `VDR_CSR_STATUS)
				nxt_rd = {30'h0, pers_ff, busy};
			else if (avs_address_i == `VDR_CSR_RDATA)
				nxt_rd = {16'h0000, rdata};
			else
				nxt_rd = 32'h0000_0000;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			op_ff   <= 4'h0;
			lane_ff <= 2'h3;
			late_ff <= 1'b0;
			adr_ff  <= 18'h00000;
			wd_ff   <= 16'h0000;
			msk_ff  <= 16'hffff;
			go_ff   <= 1'b0;
			pers_ff <= 1'b0;
			rd_ff   <= 32'h0000_0000;
			ack_ff  <= 1'b0;
		end else begin
			op_ff   <= nxt_op;
			lane_ff <= nxt_lane;
			late_ff <= nxt_late;
			adr_ff  <= nxt_adr;
			wd_ff   <= nxt_wd;
			msk_ff  <= nxt_msk;
			go_ff   <= nxt_go;
			pers_ff <= nxt_pers;
			rd_ff   <= nxt_rd;
			ack_ff  <= nxt_ack;
		end
	end

	vdr_seq u_seq (
		.clock_i                      (clock_i),
		.reset_i                      (reset_i),
		.start_i                      (go_ff),
		.op_i                         (op_ff),
		.lanes_i                      (lane_ff),
		.late_i                       (late_ff),
		.row_i                        (adr_ff[17:9]),
		.col_i                        (adr_ff[8:0]),
		.wdata_i                      (wd_ff),
		.mask_i                       (msk_ff),
		.pers_i                       (pers_ff),
		.dq_i                         (dq_i),
		.busy_o                       (busy),
		.done_o                       (done),
		.rdata_o                      (rdata),
		.addr_o                       (addr_o),
		.row_strobe_n_o               (row_strobe_n_o),
		.lower_byte_column_strobe_n_o (lower_byte_column_strobe_n_o),
		.upper_byte_column_strobe_n_o (upper_byte_column_strobe_n_o),
		.write_enable_n_o             (write_enable_n_o),
		.transfer_output_enable_n_o   (transfer_output_enable_n_o),
		.special_function_select_o    (special_function_select_o),
		.dq_o                         (dq_o),
		.dq_oe_o                      (dq_oe_o)
	);

	vdr_pers_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(done && vdr_op_e'(op_ff) == VDR_OP_REGISTER_RESET_REFRESH) |=> !pers_ff)
		else $error("persistent flag not cleared by reset refresh");
endmodule : vdr_ctrl

// ===== tb/vdr_dev_model.sv
/*
 Behavioural model of the video DRAM random port: memory array, color and mask
 registers, persistent mask state and the data pins as a tristate source.
 Assumes the testbench resolves the shared data wire and feeds it back on dq_i.
*/
`timescale 1ns/10ps
module vdr_dev_model (
	input  wire logic [8:0]  addr_i,
	input  wire logic        row_strobe_n_i,
	input  wire logic        lower_byte_column_strobe_n_i,
	input  wire logic        upper_byte_column_strobe_n_i,
	input  wire logic        write_enable_n_i,
	input  wire logic        transfer_output_enable_n_i,
	input  wire logic        special_function_select_i,
	input  wire logic [15:0] dq_i,
	output logic [15:0]      dq_o,
	output logic             dq_oe_o
);
	logic [15:0] mem [bit [17:0]];
	logic [15:0] color_r = 16'h0000;
	logic [15:0] mask_r  = 16'h0000;
	logic [15:0] rd      = 16'h0000;
	logic [15:0] wm, lm;
	logic [8:0]  row, col;
	logic        rdsf, rwe, cdsf;
	logic        pers    = 1'b0;
	logic        pend    = 1'b0;
	function automatic logic [15:0] rdm(input logic [8:0] c);
		return mem.exists({row, c}) ? mem[{row, c}] : 16'h0000;
	endfunction : rdm
	task automatic put(input logic [8:0] c, input logic [15:0] d, input logic [15:0] en);
		mem[{row, c}] = (rdm(c) & ~en) | (d & en);
	endtask : put
	task automatic load_reg;
		if (cdsf) begin
			color_r = dq_i;
		end else begin
			mask_r = dq_i;
			pers   = 1'b1;
		end
	endtask : load_reg
	// A column strobe already low at row strobe fall marks a refresh; only the
	// register-reset kind touches the persistent mask.
	always @(negedge row_strobe_n_i) begin
		row  = addr_i;
		rdsf = special_function_select_i;
		rwe  = write_enable_n_i;
		pend = 1'b0;
		if (!lower_byte_column_strobe_n_i || !upper_byte_column_strobe_n_i) begin
			if (rwe && !rdsf)
				pers = 1'b0;
		end else begin
			wm = rwe ? 16'hffff : (pers ? mask_r : dq_i);
			if (rdsf && !rwe)
				for (int c = 0; c < 512; c++)
					put(c[8:0], color_r, wm);
		end
	end
	always @(negedge lower_byte_column_strobe_n_i or negedge upper_byte_column_strobe_n_i) begin
		if (!row_strobe_n_i) begin
			col  = addr_i;
			cdsf = special_function_select_i;
			lm   = {{8{!upper_byte_column_strobe_n_i}}, {8{!lower_byte_column_strobe_n_i}}};
			if (!rdsf && cdsf) begin
				for (int i = 0; i < 8; i++)
					put({col[8:3], i[2:0]}, color_r,
						wm & lm & {{8{dq_i[i + 8]}}, {8{dq_i[i]}}});
			end else if (!write_enable_n_i) begin
				if (rdsf)
					load_reg();
				else
					put(col, dq_i, wm & lm);
			end else begin
				pend = 1'b1;
				rd   = rdsf ? (cdsf ? color_r : mask_r) : (rdm(col) & lm) | (~rdm(col) & ~lm);
			end
		end
	end
	always @(negedge write_enable_n_i) begin
		if (!row_strobe_n_i && pend) begin
			pend = 1'b0;
			if (rdsf)
				load_reg();
			else
				put(col, dq_i, wm & lm);
		end
	end
	always @(posedge row_strobe_n_i)
		pend = 1'b0;
	// Released pins show the inverse of the last data so a stale sample is caught.
	assign dq_oe_o = pend && !row_strobe_n_i && !transfer_output_enable_n_i;
	assign dq_o    = dq_oe_o ? rd : ~rd;
endmodule : vdr_dev_model

// ===== tb/video_dram_random_port_ops_tb_top.sv
/*
 Self-checking testbench for the random-port controller: table-driven device cycles
 over Avalon-MM, then reset, refusal and persistent-mask cases.
 Assumes vdr_dev_model stands on the device pins.
*/
`timescale 1ns/10ps
`include "vdr_map.svh"
module video_dram_random_port_ops_tb_top;
	import vdr_pkg::*;
	typedef struct {
		vdr_op_e     op;
		logic [1:0]  ln;
		logic        lt;
		logic [17:0] a;
		logic [15:0] d;
		logic [15:0] m;
	} vdr_row_s;
	logic        clock_i         = 1'b0;
	logic        reset_i         = 1'b1;
	logic [3:0]  avs_address_i   = 4'h0;
	logic        avs_read_i      = 1'b0;
	logic        avs_write_i     = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, q;
	logic        avs_waitrequest_o, row_n, lcas_n, ucas_n, we_n, trg_n, special_function_select, dev_oe;
	logic [15:0] dq_o, dq_oe_o, dev_dq, dq_bus, lm;
	logic [8:0]  addr_o;
	int          num_errors  = 0;
	int          check_count = 0;
	// Read rows carry the expected data in the data field.
	vdr_row_s rows [26] = '{
		'{VDR_OP_WRITE, 2'h3, 1'b0, 18'h205, 16'ha5c3, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'ha5c3, 16'h0},
		'{VDR_OP_WRITE, 2'h3, 1'b1, 18'h206, 16'h1234, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h206, 16'h1234, 16'h0},
		'{VDR_OP_WRITE, 2'h1, 1'b0, 18'h205, 16'h00ee, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'ha5ee, 16'h0},
		'{VDR_OP_READ, 2'h1, 1'b0, 18'h205, 16'ha5ee, 16'h0},
		'{VDR_OP_MWRITE, 2'h3, 1'b0, 18'h205, 16'h0000, 16'h00ff},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'ha500, 16'h0},
		'{VDR_OP_LCR, 2'h3, 1'b0, 18'h200, 16'hc3a5, 16'h0},
		'{VDR_OP_RCR, 2'h3, 1'b0, 18'h200, 16'hc3a5, 16'h0},
		'{VDR_OP_LMR, 2'h3, 1'b0, 18'h200, 16'h0f0f, 16'h0},
		'{VDR_OP_RMR, 2'h3, 1'b0, 18'h200, 16'h0f0f, 16'h0},
		'{VDR_OP_MWRITE, 2'h3, 1'b0, 18'h205, 16'hffff, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'haf0f, 16'h0},
		'{VDR_OP_REGISTER_RESET_REFRESH, 2'h3, 1'b0, 18'h200, 16'h0, 16'h0},
		'{VDR_OP_MWRITE, 2'h3, 1'b0, 18'h205, 16'h0000, 16'hf000},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'h0f0f, 16'h0},
		'{VDR_OP_FLASH, 2'h3, 1'b0, 18'h400, 16'h0, 16'h00ff},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h5ff, 16'h00a5, 16'h0},
		'{VDR_OP_BLOCK, 2'h3, 1'b0, 18'h60d, 16'h0501, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h608, 16'hc3a5, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h60a, 16'hc300, 16'h0},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h609, 16'h0000, 16'h0},
		'{VDR_OP_MBLOCK, 2'h3, 1'b0, 18'h610, 16'h0101, 16'h00ff},
		'{VDR_OP_READ, 2'h3, 1'b0, 18'h610, 16'h00a5, 16'h0}};
	assign dq_bus = (dq_oe_o & dq_o) | (~dq_oe_o & dev_dq);
	vdr_ctrl dut (
		.clock_i(clock_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.dq_i(dq_bus), .addr_o(addr_o), .row_strobe_n_o(row_n),
		.lower_byte_column_strobe_n_o(lcas_n), .upper_byte_column_strobe_n_o(ucas_n),
		.write_enable_n_o(we_n), .transfer_output_enable_n_o(trg_n),
		.special_function_select_o(special_function_select), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
	vdr_dev_model model (
		.addr_i(addr_o), .row_strobe_n_i(row_n), .lower_byte_column_strobe_n_i(lcas_n),
		.upper_byte_column_strobe_n_i(ucas_n), .write_enable_n_i(we_n),
		.transfer_output_enable_n_i(trg_n), .special_function_select_i(special_function_select),
		.dq_i(dq_bus), .dq_o(dev_dq), .dq_oe_o(dev_oe));
	always #50 clock_i = ~clock_i;
	task automatic check_val(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check_val
	task automatic av_xfer(input logic rd, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		avs_address_i   <= a;
		avs_read_i      <= rd;
		avs_write_i     <= !rd;
		avs_writedata_i <= wd;
		// Waits as long as the slave asks; only the watchdog ends a hung access.
		do begin
			@(posedge clock_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : av_xfer
	task automatic wait_idle;
		do begin
			av_xfer(1'b1, `VDR_CSR_STATUS, 32'h0);
		end while (q[`VDR_STAT_BUSY_BIT] !== 1'b0);
	endtask : wait_idle
	task automatic run_op(input vdr_row_s t);
		av_xfer(1'b0, `VDR_CSR_ADDR, {14'h0, t.a});
		av_xfer(1'b0, `VDR_CSR_WDATA, {16'h0, t.d});
		av_xfer(1'b0, `VDR_CSR_MASK, {16'h0, t.m});
		av_xfer(1'b0, `VDR_CSR_CTRL, {21'h0, t.lt, t.ln, t.op, 4'h1});
		wait_idle();
	endtask : run_op
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	// Write data must never meet an enabled device output.
	always @(posedge clock_i) begin
		if (|dq_oe_o) begin
			check_val("output enable while driving", {31'h0, trg_n}, 32'h1);
			check_val("bus contention", {31'h0, dev_oe}, 32'h0);
		end
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		check_val("strobes after reset", {28'h0, row_n, lcas_n, ucas_n, we_n}, 32'hf);
		check_val("data enable after reset", {16'h0, dq_oe_o}, 32'h0);
		foreach (rows[i]) begin
			run_op(rows[i]);
			if (rows[i].op inside {VDR_OP_READ, VDR_OP_RMR, VDR_OP_RCR}) begin
				av_xfer(1'b1, `VDR_CSR_RDATA, 32'h0);
				lm = {{8{rows[i].ln[1]}}, {8{rows[i].ln[0]}}};
				check_val("read data", {16'h0, q[15:0] & lm}, {16'h0, rows[i].d & lm});
			end
		end
		run_op('{VDR_OP_LMR, 2'h3, 1'b0, 18'h200, 16'h00ff, 16'h0});
		check_val("persistent flag set", {31'h0, q[`VDR_STAT_PERS_BIT]}, 32'h1);
		run_op('{VDR_OP_REGISTER_RESET_REFRESH, 2'h3, 1'b0, 18'h200, 16'h0, 16'h0});
		check_val("persistent flag clear", {31'h0, q[`VDR_STAT_PERS_BIT]}, 32'h0);
		run_op('{VDR_OP_MWRITE, 2'h3, 1'b0, 18'h205, 16'hffff, 16'hf000});
		run_op('{VDR_OP_READ, 2'h3, 1'b0, 18'h205, 16'h0, 16'h0});
		av_xfer(1'b1, `VDR_CSR_RDATA, 32'h0);
		check_val("new mask after reset refresh", {16'h0, q[15:0]}, 32'hff0f);
		av_xfer(1'b0, `VDR_CSR_ADDR, 32'h207);
		av_xfer(1'b0, `VDR_CSR_WDATA, 32'h1111);
		av_xfer(1'b0, `VDR_CSR_CTRL, {21'h0, 1'b0, 2'h3, VDR_OP_WRITE, 4'h1});
		av_xfer(1'b1, `VDR_CSR_STATUS, 32'h0);
		check_val("busy", {31'h0, q[`VDR_STAT_BUSY_BIT]}, 32'h1);
		av_xfer(1'b0, `VDR_CSR_WDATA, 32'h2222);
		wait_idle();
		run_op('{VDR_OP_READ, 2'h3, 1'b0, 18'h207, 16'h0, 16'h0});
		av_xfer(1'b1, `VDR_CSR_RDATA, 32'h0);
		check_val("write during busy", {16'h0, q[15:0]}, 32'h1111);
		av_xfer(1'b1, `VDR_CSR_WDATA, 32'h0);
		check_val("unmapped read", q, 32'h0);
		// Reset in mid-operation must put every strobe back to idle by the time reset drops.
		av_xfer(1'b0, `VDR_CSR_CTRL, {21'h0, 1'b0, 2'h3, VDR_OP_READ, 4'h1});
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		check_val("strobes after mid reset", {28'h0, row_n, lcas_n, ucas_n, we_n}, 32'hf);
		av_xfer(1'b1, `VDR_CSR_STATUS, 32'h0);
		check_val("status after mid reset", {30'h0, q[1:0]}, 32'h0);
		complete_run();
	end
endmodule : video_dram_random_port_ops_tb_top
